// ### rac_pkg.sv
// Constants and types for the receive auxiliary control block
package rac_pkg;
	// Register indexes; byte address is four times the index
	localparam logic [9:0] IDX_OPC2   = 10'h008;
	localparam logic [9:0] IDX_PIN0   = 10'h00B;
	localparam logic [9:0] IDX_PIN1   = 10'h00C;
	localparam logic [9:0] IDX_PIN2   = 10'h00D;
	localparam logic [9:0] IDX_IOC    = 10'h00E;
	localparam logic [9:0] IDX_WEXP   = 10'h014;
	localparam logic [9:0] IDX_LDCD   = 10'h019;
	localparam logic [9:0] IDX_RSSI   = 10'h026;
	localparam logic [9:0] IDX_THR    = 10'h027;
	localparam logic [9:0] IDX_STAT   = 10'h028;
	// Reset values
	localparam logic [7:0] RST_OPC2   = 8'h00;
	localparam logic [7:0] RST_PIN    = 8'h00;
	localparam logic [7:0] RST_IOC    = 8'h00;
	localparam logic [4:0] RST_WEXP   = 5'h03;
	localparam logic [7:0] RST_LDCD   = 8'h00;
	localparam logic [7:0] RST_RSSI   = 8'h00;
	localparam logic [7:0] RST_THR    = 8'h00;
	// Field positions
	localparam int ANTDIV_LSB = 5;
	localparam int ENLDM_BIT  = 2;
	localparam int DRV_LSB    = 6;
	localparam int PUP_BIT    = 5;
	localparam int FN_LSB     = 0;
	// Pin function codes
	localparam logic [4:0] FN_DEFAULT = 5'h00;
	localparam logic [3:0] FN_RSSI_LO = 4'hE;
	localparam logic [4:0] FN_DIO     = 5'h0A;
	localparam logic [4:0] FN_ANT1    = 5'h17;
	localparam logic [4:0] FN_ANT2    = 5'h18;
	localparam logic [4:0] FN_LDC_RX  = 5'h1D;
	// Timing
	localparam int CLK_PERIOD_PS    = 25000;
	localparam int DWELL_NS         = 4000;
	localparam int DWELL_BEACON_NS  = 2000;
	localparam int DWELL_CYC        = (DWELL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int DWELL_BCN_CYC    =
		(DWELL_BEACON_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int EXT_W            = 48;
	localparam int DWELL_W          = 16;

	typedef enum logic [1:0] {
		LDC_IDLE   = 2'b00,
		LDC_LISTEN = 2'b01,
		LDC_EXTEND = 2'b10
	} rac_ldc_state_type;

	typedef enum logic [1:0] {
		DIV_OFF    = 2'b00,
		DIV_SEARCH = 2'b01,
		DIV_HOLD   = 2'b10
	} rac_div_state_type;

	typedef struct packed {
		logic       shutdown;
		logic       por;
		logic       mcu_clk;
		logic       wake_tick;
		logic       preamble_ok;
		logic       sync_ok;
		logic       search_fail;
		logic       rx_active;
		logic       tx_active;
		logic       rssi_strobe;
		logic [7:0] rssi;
	} rac_radio_type;

	typedef struct packed {
		logic [2:0] o;
		logic [2:0] oe;
	} rac_pads_type;

	typedef struct packed {
		logic [7:0]          opc2;
		logic [2:0][7:0]     pin_cfg;
		logic [7:0]          ioc;
		logic [4:0]          wexp;
		logic [7:0]          ldcd;
		logic [7:0]          rssi;
		logic [7:0]          thr;
		logic [2:0]          sync;
		logic                tick_lvl;
		rac_ldc_state_type   ldc_state;
		logic [EXT_W-1:0]    ext_cnt;
		rac_div_state_type   div_state;
		logic                rx_prev;
		logic                ant_cur;
		logic                ant_sel;
		logic [DWELL_W-1:0]  dwell;
		logic [7:0]          rssi_a;
		logic [7:0]          rssi_b;
		logic                rssi_flag;
		logic [31:0]         prdata;
		rac_pads_type        pads;
	} rac_state_type;
endpackage

// ### rac_core.sv
// Receive auxiliary control: low duty receive, pin routing, antenna diversity, signal strength
`timescale 1ns/1ps
module rac_core #(
	parameter int DWELL_CYCLES  = rac_pkg::DWELL_CYC,
	parameter int BEACON_CYCLES = rac_pkg::DWELL_BCN_CYC
) (
	// Clock and reset
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	// APB slave
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [11:0]            paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	// Radio status, same clock
	input  wire rac_pkg::rac_radio_type radio,
	// Slow oscillator from its own domain
	input  wire logic                   tick_32k,
	// Receiver enable from low duty control
	output logic                        ldc_rx_on,
	// Pin pads
	output rac_pkg::rac_pads_type       pads,
	output logic      [2:0][1:0]        pin_drive_strength,
	output logic      [2:0]             pin_pullup
);
	import rac_pkg::*;

	rac_state_type q;
	rac_state_type d;

	logic             setup;
	logic             access;
	logic             addr_ok;
	logic [9:0]       idx;
	logic             hit;
	logic [7:0]       rd_byte;
	logic             wr;
	logic             tick_rise;
	logic             rxtx;
	logic             rx_rise;
	logic             ant_use;
	logic             ant1;
	logic             ant2;
	logic [2:0]       antdiv;
	logic [EXT_W-1:0] ext_load;
	logic [4:0]       code;
	logic [DWELL_W-1:0] dwell_max;

	assign setup   = psel & ~penable;
	assign access  = psel & penable;
	assign idx     = paddr[11:2];
	assign addr_ok = (paddr[1:0] == 2'b00) & hit;
	assign wr      = access & pwrite & addr_ok;
	assign pready  = access;
	assign pslverr = access & ~addr_ok;
	assign prdata  = q.prdata;
	assign antdiv  = q.opc2[ANTDIV_LSB +: 3];
	assign rxtx    = radio.rx_active | radio.tx_active;
	assign rx_rise = radio.rx_active & ~q.rx_prev;

	// Address decode and read data
	always_comb begin
		hit     = 1'b1;
		rd_byte = 8'h00;
		if (idx == IDX_OPC2) begin
			rd_byte = q.opc2;
		end else if (idx == IDX_PIN0) begin
			rd_byte = q.pin_cfg[0];
		end else if (idx == IDX_PIN1) begin
			rd_byte = q.pin_cfg[1];
		end else if (idx == IDX_PIN2) begin
			rd_byte = q.pin_cfg[2];
		end else if (idx == IDX_IOC) begin
			rd_byte = q.ioc;
		end else if (idx == IDX_WEXP) begin
			rd_byte = {3'h0, q.wexp};
		end else if (idx == IDX_LDCD) begin
			rd_byte = q.ldcd;
		end else if (idx == IDX_RSSI) begin
			rd_byte = q.rssi;
		end else if (idx == IDX_THR) begin
			rd_byte = q.thr;
		end else if (idx == IDX_STAT) begin
			rd_byte = {q.rssi_flag, q.ant_sel, q.ant_cur, 1'b0,
				q.div_state, q.ldc_state};
		end else begin
			hit = 1'b0;
		end
	end

	// Antenna pin levels
	always_comb begin
		ant_use = (q.div_state == DIV_HOLD) ? q.ant_sel : q.ant_cur;
		if (!antdiv[2]) begin
			if (rxtx) begin
				ant1 = antdiv[0];
				ant2 = ~antdiv[0];
			end else begin
				ant1 = antdiv[1];
				ant2 = antdiv[1];
			end
		end else begin
			if (rxtx) begin
				ant1 = ~ant_use;
				ant2 = ant_use;
			end else begin
				ant1 = antdiv[0];
				ant2 = antdiv[0];
			end
		end
	end

	// Receive-on length in slow ticks
	assign ext_load = EXT_W'({q.ldcd, 2'b00}) << q.wexp;

	// Shorter dwell in beacon mode
	assign dwell_max = (antdiv[2:1] == 2'b11) ? DWELL_W'(BEACON_CYCLES)
		: DWELL_W'(DWELL_CYCLES);

	// Slow tick edge once stages two and three agree
	assign tick_rise = (q.sync[2] == q.sync[1]) & q.sync[1] & ~q.tick_lvl;

	always_comb begin
		d      = q;
		code   = 5'h00;
		d.sync = {q.sync[1:0], tick_32k};
		if (q.sync[2] == q.sync[1]) begin
			d.tick_lvl = q.sync[1];
		end
		d.rx_prev = radio.rx_active;

		// Register writes and read capture
		if (setup) begin
			d.prdata = {24'h000000, rd_byte};
		end
		if (wr) begin
			if (idx == IDX_OPC2) begin
				d.opc2 = pwdata[7:0];
			end else if (idx == IDX_PIN0) begin
				d.pin_cfg[0] = pwdata[7:0];
			end else if (idx == IDX_PIN1) begin
				d.pin_cfg[1] = pwdata[7:0];
			end else if (idx == IDX_PIN2) begin
				d.pin_cfg[2] = pwdata[7:0];
			end else if (idx == IDX_IOC) begin
				d.ioc = pwdata[7:0];
			end else if (idx == IDX_WEXP) begin
				d.wexp = pwdata[4:0];
			end else if (idx == IDX_LDCD) begin
				d.ldcd = pwdata[7:0];
			end else if (idx == IDX_THR) begin
				d.thr = pwdata[7:0];
			end
		end

		// Strength sample
		if (radio.rssi_strobe) begin
			d.rssi = radio.rssi;
		end

		// Clear channel decision at preamble evaluation
		if (radio.preamble_ok) begin
			d.rssi_flag = (radio.rssi > q.thr);
		end

		// Low duty cycle receive
		if (!q.opc2[ENLDM_BIT]) begin
			d.ldc_state = LDC_IDLE;
			d.ext_cnt   = '0;
		end else begin
			case (q.ldc_state)
				LDC_IDLE: begin
					if (radio.wake_tick) begin
						d.ldc_state = LDC_LISTEN;
					end
				end
				LDC_LISTEN: begin
					if (radio.preamble_ok && radio.sync_ok) begin
						d.ext_cnt = ext_load;
						if (ext_load == '0) begin
							d.ldc_state = LDC_IDLE;
						end else begin
							d.ldc_state = LDC_EXTEND;
						end
					end else if (radio.search_fail) begin
						d.ldc_state = LDC_IDLE;
					end
				end
				LDC_EXTEND: begin
					if (tick_rise) begin
						if (q.ext_cnt <= EXT_W'(1)) begin
							d.ext_cnt   = '0;
							d.ldc_state = LDC_IDLE;
						end else begin
							d.ext_cnt = q.ext_cnt - EXT_W'(1);
						end
					end
				end
				default: begin
					d.ldc_state = LDC_IDLE;
				end
			endcase
		end

		// Antenna diversity
		if (!antdiv[2]) begin
			d.div_state = DIV_OFF;
			d.dwell     = '0;
		end else begin
			case (q.div_state)
				DIV_OFF: begin
					if (rx_rise) begin
						d.div_state = DIV_SEARCH;
						d.dwell     = '0;
					end
				end
				DIV_SEARCH: begin
					if (radio.rssi_strobe) begin
						if (q.ant_cur) begin
							d.rssi_b = radio.rssi;
						end else begin
							d.rssi_a = radio.rssi;
						end
					end
					if (radio.preamble_ok) begin
						d.ant_sel   = (q.rssi_b > q.rssi_a);
						d.ant_cur   = (q.rssi_b > q.rssi_a);
						d.div_state = DIV_HOLD;
					end else if (!radio.rx_active) begin
						d.div_state = DIV_HOLD;
					end else if (q.dwell >= dwell_max - DWELL_W'(1)) begin
						d.dwell   = '0;
						d.ant_cur = ~q.ant_cur;
					end else begin
						d.dwell = q.dwell + DWELL_W'(1);
					end
				end
				DIV_HOLD: begin
					if (rx_rise) begin
						d.div_state = DIV_SEARCH;
						d.dwell     = '0;
						d.rssi_a    = '0;
						d.rssi_b    = '0;
					end
				end
				default: begin
					d.div_state = DIV_OFF;
				end
			endcase
		end

		// Pin function routing
		for (int i = 0; i < 3; i++) begin
			code         = q.pin_cfg[i][FN_LSB +: 5];
			d.pads.oe[i] = 1'b1;
			d.pads.o[i]  = 1'b0;
			if (radio.shutdown) begin
				d.pads.o[i] = 1'b0;
			end else if (code == FN_DEFAULT) begin
				if (i == 0) begin
					d.pads.o[i] = radio.por;
				end else if (i == 1) begin
					d.pads.o[i] = ~radio.por;
				end else begin
					d.pads.o[i] = radio.mcu_clk;
				end
			end else if (code[3:0] == FN_RSSI_LO) begin
				d.pads.o[i] = q.rssi_flag;
			end else if (code == FN_ANT1) begin
				d.pads.o[i] = ant1;
			end else if (code == FN_ANT2) begin
				d.pads.o[i] = ant2;
			end else if (code == FN_LDC_RX) begin
				d.pads.o[i] = (q.ldc_state != LDC_IDLE);
			end else if (code == FN_DIO) begin
				d.pads.o[i] = q.ioc[i];
			end else begin
				d.pads.oe[i] = 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q.opc2      <= RST_OPC2;
			q.pin_cfg   <= {3{RST_PIN}};
			q.ioc       <= RST_IOC;
			q.wexp      <= RST_WEXP;
			q.ldcd      <= RST_LDCD;
			q.rssi      <= RST_RSSI;
			q.thr       <= RST_THR;
			q.sync      <= 3'h0;
			q.tick_lvl  <= 1'b0;
			q.ldc_state <= LDC_IDLE;
			q.ext_cnt   <= '0;
			q.div_state <= DIV_OFF;
			q.rx_prev   <= 1'b0;
			q.ant_cur   <= 1'b0;
			q.ant_sel   <= 1'b0;
			q.dwell     <= '0;
			q.rssi_a    <= 8'h00;
			q.rssi_b    <= 8'h00;
			q.rssi_flag <= 1'b0;
			q.prdata    <= 32'h00000000;
			q.pads.o    <= 3'h0;
			q.pads.oe   <= 3'h7;
		end else begin
			q <= d;
		end
	end

	// Pad configuration straight from registers
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			pin_drive_strength[i] = q.pin_cfg[i][DRV_LSB +: 2];
			pin_pullup[i]         = q.pin_cfg[i][PUP_BIT];
		end
	end

	assign pads      = q.pads;
	assign ldc_rx_on = (q.ldc_state != LDC_IDLE);
endmodule

// ### rac_core_chk.sv
// Port assertions for the receive auxiliary control block
`timescale 1ns/1ps
module rac_core_chk
	import rac_pkg::*;
(
	// Clock and reset
	input wire logic                   pclk,
	input wire logic                   presetn,
	// APB
	input wire logic                   psel,
	input wire logic                   penable,
	input wire logic                   pwrite,
	input wire logic [11:0]            paddr,
	input wire logic [31:0]            pwdata,
	input wire logic                   pslverr,
	// Radio and pins
	input wire rac_pkg::rac_radio_type radio,
	input wire logic                   ldc_rx_on,
	input wire rac_pkg::rac_pads_type  pads,
	input wire logic [2:0][1:0]        pin_drive_strength
);
	logic [2:0] md_q;
	logic [4:0] f0_q;
	logic [4:0] f1_q;
	logic       wr;
	logic       ant_ok;
	logic       rxtx;
	logic       idle_lvl;
	assign wr = psel && penable && pwrite;
	assign ant_ok = f0_q == FN_ANT1 && f1_q == FN_ANT2 && !radio.shutdown;
	assign rxtx = radio.rx_active || radio.tx_active;
	assign idle_lvl = md_q[2] ? md_q[0] : md_q[1];
	// Shadow of antenna mode and pin functions
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			md_q <= 3'h0;
			f0_q <= 5'h00;
			f1_q <= 5'h00;
		end else if (wr) begin
			if (paddr == 12'h020)
				md_q <= pwdata[7:5];
			if (paddr == 12'h02C)
				f0_q <= pwdata[4:0];
			if (paddr == 12'h030)
				f1_q <= pwdata[4:0];
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence wr_pin0_s;
		wr && paddr == 12'h02C;
	endsequence
	sequence pads_off_s;
		pads.o == 3'h0 && pads.oe == 3'h7;
	endsequence
	shut_low_a: assert property (radio.shutdown |=> pads_off_s)
		else $error("pads not low in shutdown");
	drive_map_a: assert property (
		wr_pin0_s |=> pin_drive_strength[0] == $past(pwdata[7:6]))
		else $error("drive strength not taken from write");
	ro_noerr_a: assert property (
		psel && penable && paddr == 12'h098 |-> !pslverr)
		else $error("strength register access flagged");
	sleep_hold_a: assert property (
		!ldc_rx_on && !radio.wake_tick |=> !ldc_rx_on)
		else $error("receiver woke without wake period");
	fixed_ant_a: assert property (
		ant_ok && !md_q[2] && rxtx |=> pads.o[1:0] == {!$past(md_q[0]), $past(md_q[0])})
		else $error("fixed antenna pins wrong");
	idle_ant_a: assert property (
		ant_ok && !rxtx |=> pads.o[1:0] == {2{$past(idle_lvl)}})
		else $error("idle antenna pins wrong");
	div_compl_a: assert property (
		ant_ok && md_q[2] && rxtx |=> pads.o[0] != pads.o[1])
		else $error("diversity pins not complementary");
	pin_default_a: assert property (
		f0_q == 5'h00 && f1_q == 5'h00 && !radio.shutdown
		|=> pads.o[1:0] == {!$past(radio.por), $past(radio.por)})
		else $error("default pin functions wrong");
endmodule

bind rac_core rac_core_chk i_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pslverr(pslverr), .radio(radio),
	.ldc_rx_on(ldc_rx_on), .pads(pads), .pin_drive_strength(pin_drive_strength)
);

// ### rac_far_side.sv
// Far side model: slow oscillator and external antenna switch
`timescale 1ns/1ps
module rac_far_side
	import rac_pkg::*;
#(
	parameter int TICK_HALF_NS = 200
) (
	// Pins from the block
	input wire rac_pkg::rac_pads_type pads,
	// Slow oscillator, shortened period
	output logic                      tick_32k,
	// Switch has antenna 2 connected
	output logic                      ant2_on
);
	initial begin
		tick_32k = 1'b0;
		#7;
		forever #(TICK_HALF_NS) tick_32k = ~tick_32k;
	end
	// Antenna 2 only on a clean select
	assign ant2_on = pads.o[1] && !pads.o[0];
endmodule

// ### rac_core_tb.sv
// Self-checking bench for the receive auxiliary control block
`timescale 1ns/1ps
module rac_core_tb;
	import rac_pkg::*;
	typedef struct packed {
		logic [11:0] a;
		logic [7:0]  rst;
		logic [7:0]  wr;
		logic [7:0]  rd;
		logic        err;
	} rac_row_type;
	logic            pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0]     paddr;
	logic [31:0]     pwdata, prdata, rd;
	logic            tick_32k, ldc_rx_on, ant2_on, er, p;
	rac_radio_type   radio;
	rac_pads_type    pads;
	logic [2:0][1:0] drv;
	logic [2:0]      pup;
	int              num_errors, samples_checked, n;
	rac_row_type     rows [8];
	rac_core #(.DWELL_CYCLES(4), .BEACON_CYCLES(2)) i_dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .radio(radio),
		.tick_32k(tick_32k), .ldc_rx_on(ldc_rx_on), .pads(pads),
		.pin_drive_strength(drv), .pin_pullup(pup));
	rac_far_side i_far (.pads(pads), .tick_32k(tick_32k), .ant2_on(ant2_on));
	task automatic step(input int k);
		repeat (k) @(posedge pclk);
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		samples_checked++;
		if (s !== x) begin
			num_errors++;
			$display("CHECK FAILED %0t: got %0h expected %0h", $time, s, x);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rx_up();
		radio.rx_active <= 1'b0;
		step(3);
		radio.rx_active <= 1'b1;
		step(3);
	endtask
	task automatic preamble(input logic [7:0] s);
		radio.rssi <= s;
		radio.preamble_ok <= 1'b1;
		radio.sync_ok <= 1'b1;
		step(1);
		radio.preamble_ok <= 1'b0;
		radio.sync_ok <= 1'b0;
	endtask
	task automatic wake_up();
		radio.wake_tick <= 1'b1;
		step(1);
		radio.wake_tick <= 1'b0;
		step(2);
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	initial begin
		#500000;
		num_errors++;
		finish_test();
	end
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		radio = '0;
		rows = '{'{12'h020, 8'h00, 8'hA4, 8'hA4, 1'b0}, '{12'h02C, 8'h00, 8'hC3, 8'hC3, 1'b0},
			'{12'h034, 8'h00, 8'hFF, 8'hFF, 1'b0}, '{12'h038, 8'h00, 8'h07, 8'h07, 1'b0},
			'{12'h050, 8'h03, 8'hFF, 8'h1F, 1'b0}, '{12'h09C, 8'h00, 8'h3C, 8'h3C, 1'b0},
			'{12'h098, 8'h00, 8'hFF, 8'h00, 1'b0}, '{12'h0FC, 8'h00, 8'hFF, 8'h00, 1'b1}};
		step(4);
		presetn <= 1'b1;
		foreach (rows[i]) begin
			apb(1'b0, rows[i].a, 8'h00);
			chk(rd, {24'h0, rows[i].rst});
			apb(1'b1, rows[i].a, rows[i].wr);
			chk(er, rows[i].err);
			apb(1'b0, rows[i].a, 8'h00);
			chk(rd, {24'h0, rows[i].rd});
		end
		$display("registers done");
		for (int d = 0; d < 4; d++) begin
			apb(1'b1, 12'h02C, {d[1:0], 6'h20});
			step(1);
			chk(drv[0], d[1:0]);
			chk(pup[0], 1'b1);
		end
		apb(1'b1, 12'h034, 8'h00);
		for (int v = 0; v < 2; v++) begin
			radio.por <= v[0];
			radio.mcu_clk <= v[0];
			step(3);
			chk(pads.o, {v[0], !v[0], v[0]});
		end
		radio.shutdown <= 1'b1;
		step(3);
		chk(pads, {3'h0, 3'h7});
		radio.shutdown <= 1'b0;
		apb(1'b1, 12'h034, 8'h0A);
		step(2);
		chk(pads.o[2], 1'b1);
		$display("pins done");
		apb(1'b1, 12'h02C, 8'h17);
		apb(1'b1, 12'h030, 8'h18);
		for (int m = 0; m < 8; m++) begin
			apb(1'b1, 12'h020, {m[2:0], 5'h00});
			radio.rx_active <= 1'b1;
			step(3);
			if (m < 4)
				chk(pads.o[1:0], {!m[0], m[0]});
			else
				chk(pads.o[0] ^ pads.o[1], 1'b1);
			radio.rx_active <= 1'b0;
			step(3);
			chk(pads.o[1:0], m[2] ? {2{m[0]}} : {2{m[1]}});
		end
		for (int b = 0; b < 2; b++) begin
			apb(1'b1, 12'h020, b ? 8'hC0 : 8'h80);
			rx_up();
			n = 0;
			p = pads.o[0];
			repeat (16) begin
				step(1);
				n += (pads.o[0] !== p);
				p = pads.o[0];
			end
			chk(n, b ? 8 : 4);
		end
		apb(1'b1, 12'h034, 8'h0E);
		apb(1'b1, 12'h09C, 8'h40);
		apb(1'b1, 12'h020, 8'h80);
		rx_up();
		// Strobe once per antenna, just after it settles
		repeat (2) begin
			p = pads.o[0];
			while (pads.o[0] === p)
				step(1);
			radio.rssi <= ant2_on ? 8'h50 : 8'h20;
			radio.rssi_strobe <= 1'b1;
			step(1);
			radio.rssi_strobe <= 1'b0;
		end
		preamble(8'h50);
		step(6);
		chk(pads.o, 3'b110);
		radio.rx_active <= 1'b0;
		radio.tx_active <= 1'b1;
		step(3);
		chk(pads.o[1:0], 2'b10);
		radio.tx_active <= 1'b0;
		rx_up();
		preamble(8'h40);
		step(3);
		chk(pads.o[2], 1'b0);
		$display("diversity done");
		apb(1'b1, 12'h050, 8'h00);
		apb(1'b1, 12'h064, 8'h01);
		apb(1'b1, 12'h020, 8'h04);
		apb(1'b1, 12'h034, 8'h1D);
		wake_up();
		chk(ldc_rx_on, 1'b1);
		chk(pads.o[2], 1'b1);
		radio.search_fail <= 1'b1;
		step(1);
		radio.search_fail <= 1'b0;
		step(40);
		chk(ldc_rx_on, 1'b0);
		wake_up();
		@(negedge tick_32k);
		@(posedge pclk);
		preamble(8'h10);
		repeat (3) @(posedge tick_32k);
		step(6);
		chk(ldc_rx_on, 1'b1);
		@(posedge tick_32k);
		step(6);
		chk(ldc_rx_on, 1'b0);
		wake_up();
		presetn <= 1'b0;
		step(2);
		chk(ldc_rx_on, 1'b0);
		presetn <= 1'b1;
		apb(1'b0, 12'h050, 8'h00);
		chk(rd, 32'h3);
		$display("low duty and reset done");
		finish_test();
	end
endmodule
